// ===== src/gpio_edge_detect.sv
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
module gpio_edge_detect
  import gpio_edge_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [27:0] pin_in,
  output logic [10:0]      pin_irq,
  output logic             group_irq,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  typedef struct packed {
    logic [27:0] sync1;
    logic [27:0] sync2;
    logic [27:0] prev;
    logic [27:0] rise_en;
    logic [27:0] fall_en;
    logic [27:0] status;
    logic        aw_held;
    logic [7:0]  awaddr;
    logic        w_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_s;

  state_s st_q;
  state_s st_d;

  // byte-lane merge of a write into a 28-bit field
  function automatic logic [27:0] merge_lanes(input logic [27:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = {4'h0, old};
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r[27:0];
  endfunction

  // byte-lane mask of ones written
  function automatic logic [27:0] ones_written(input logic [31:0] data,
                                               input logic [3:0]  strb);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        m[8*i +: 8] = data[8*i +: 8];
      end
    end
    return m[27:0];
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    return (a == RISE_EN_OFF) || (a == FALL_EN_OFF) || (a == STATUS_OFF);
  endfunction

  logic [27:0] edge_hit;
  logic        aw_take;
  logic        w_take;
  logic        wr_go;
  logic        rd_go;
  logic [27:0] clr_mask;

  //////////////////////////////////////////////////////////////////////////
  // edge detection, registers and bus
  always_comb
  begin
    st_d = st_q;
    clr_mask = 28'h0;
    st_d.sync1 = pin_in;                                     // R13
    st_d.sync2 = st_q.sync1;                                 // R13
    st_d.prev  = st_q.sync2;                                 // R13
    edge_hit = (st_q.rise_en & st_q.sync2 & ~st_q.prev)      // R1 R3
             | (st_q.fall_en & ~st_q.sync2 & st_q.prev);     // R2 R3

    aw_take = s_axi_awvalid && !st_q.aw_held && !st_q.bvalid;
    w_take  = s_axi_wvalid && !st_q.w_held && !st_q.bvalid;
    if (aw_take)
    begin
      st_d.aw_held = 1'b1;
      st_d.awaddr  = s_axi_awaddr[7:0];
    end
    if (w_take)
    begin
      st_d.w_held = 1'b1;
      st_d.wdata  = s_axi_wdata;
      st_d.wstrb  = s_axi_wstrb;
    end
    wr_go = st_q.aw_held && st_q.w_held;
    if (wr_go)
    begin
      st_d.aw_held = 1'b0;
      st_d.w_held  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = addr_hit(st_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      case (st_q.awaddr)                                     // R12
        RISE_EN_OFF: st_d.rise_en = merge_lanes(st_q.rise_en,
                                    st_q.wdata, st_q.wstrb); // R4
        FALL_EN_OFF: st_d.fall_en = merge_lanes(st_q.fall_en,
                                    st_q.wdata, st_q.wstrb); // R4
        STATUS_OFF:  clr_mask = ones_written(st_q.wdata,
                                st_q.wstrb);                 // R7 R8
        default:     clr_mask = 28'h0;
      endcase
    end
    else if (st_q.bvalid && s_axi_bready)
    begin
      st_d.bvalid = 1'b0;
    end
    st_d.status = (st_q.status & ~clr_mask) | edge_hit;      // R6 R7 R14

    rd_go = s_axi_arvalid && !st_q.rvalid;
    if (rd_go)
    begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = addr_hit(s_axi_araddr[7:0]) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr[7:0])                               // R12
        RISE_EN_OFF: st_d.rdata = {4'h0, st_q.rise_en};      // R4
        FALL_EN_OFF: st_d.rdata = {4'h0, st_q.fall_en};      // R4
        STATUS_OFF:  st_d.rdata = {4'h0, st_q.status};       // R6
        default:     st_d.rdata = 32'h0;
      endcase
    end
    else if (st_q.rvalid && s_axi_rready)
    begin
      st_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q         <= '0;
      // pin history follows the pins in reset: no false edge on release
      st_q.sync1   <= st_d.sync1;                            // R13
      st_q.sync2   <= st_d.sync2;                            // R13
      st_q.prev    <= st_d.prev;                             // R13
      st_q.rise_en <= ENABLE_RESET;                          // R5
      st_q.fall_en <= ENABLE_RESET;                          // R5
      st_q.status  <= STATUS_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign pin_irq       = st_q.status[SOLO_PINS-1:0];         // R10 R11
  assign group_irq     = |st_q.status[NUM_PINS-1:SOLO_PINS]; // R9 R11
  assign s_axi_awready = !st_q.aw_held && !st_q.bvalid;
  assign s_axi_wready  = !st_q.w_held && !st_q.bvalid;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;

  //////////////////////////////////////////////////////////////////////////
  // per-pin assertions
  for (genvar p = 0; p < NUM_PINS; p++)
  begin : pin_chk
    rise_sets_status_a: assert property ( // R1
      @(posedge aclk) disable iff (!aresetn)
      (st_q.rise_en[p] && st_q.sync2[p] && !st_q.prev[p])
      |=> st_q.status[p])
      else $error("rising edge did not set status");

    fall_sets_status_a: assert property ( // R2
      @(posedge aclk) disable iff (!aresetn)
      (st_q.fall_en[p] && !st_q.sync2[p] && st_q.prev[p])
      |=> st_q.status[p])
      else $error("falling edge did not set status");

    no_enable_no_set_a: assert property ( // R3
      @(posedge aclk) disable iff (!aresetn)
      (!st_q.rise_en[p] && !st_q.fall_en[p] && !st_q.status[p])
      |=> !st_q.status[p])
      else $error("status set with both enables off");

    status_sticky_a: assert property ( // R7
      @(posedge aclk) disable iff (!aresetn)
      (st_q.status[p] && !clr_mask[p])
      |=> st_q.status[p])
      else $error("status bit dropped without clear");

    one_clears_bit_a: assert property ( // R7
      @(posedge aclk) disable iff (!aresetn)
      (clr_mask[p] && !edge_hit[p])
      |=> !st_q.status[p])
      else $error("written one did not clear status");

    zero_write_keeps_a: assert property ( // R8
      @(posedge aclk) disable iff (!aresetn)
      (wr_go && st_q.awaddr == STATUS_OFF && !st_q.wdata[p]
        && st_q.status[p])
      |=> st_q.status[p])
      else $error("written zero cleared status");

    edge_beats_clear_a: assert property ( // R14
      @(posedge aclk) disable iff (!aresetn)
      (clr_mask[p] && edge_hit[p])
      |=> st_q.status[p])
      else $error("edge lost against clear");
  end

  for (genvar p = 0; p < SOLO_PINS; p++)
  begin : solo_chk
    pin_irq_a: assert property ( // R10
      @(posedge aclk) disable iff (!aresetn)
      edge_hit[p]
      |=> pin_irq[p])
      else $error("pin request missing");

    pin_irq_low_a: assert property ( // R10
      @(posedge aclk) disable iff (!aresetn)
      (!st_q.status[p] && !edge_hit[p])
      |=> !pin_irq[p])
      else $error("pin request without status");
  end

  //////////////////////////////////////////////////////////////////////////
  // request, register and bus assertions
  group_irq_a: assert property ( // R9
    @(posedge aclk) disable iff (!aresetn)
    (edge_hit[27:11] != 17'h0)
    |=> group_irq)
    else $error("group request missing");

  group_irq_low_a: assert property ( // R9
    @(posedge aclk) disable iff (!aresetn)
    (st_q.status[27:11] == 17'h0 && edge_hit[27:11] == 17'h0)
    |=> !group_irq)
    else $error("group request without status");

  reserved_reads_zero_a: assert property ( // R4
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid
    |-> s_axi_rdata[31:28] == 4'h0)
    else $error("reserved bits read nonzero");

  reset_enables_a: assert property ( // R5
    @(posedge aclk)
    $rose(aresetn)
    |-> st_q.rise_en == ENABLE_RESET && st_q.fall_en == ENABLE_RESET
      && st_q.status == STATUS_RESET)
    else $error("reset value wrong");

  read_status_a: assert property ( // R6
    @(posedge aclk) disable iff (!aresetn)
    (rd_go && s_axi_araddr[7:0] == STATUS_OFF)
    |=> s_axi_rdata == {4'h0, $past(st_q.status)})
    else $error("status read mismatch");

  read_rise_a: assert property ( // R12
    @(posedge aclk) disable iff (!aresetn)
    (rd_go && s_axi_araddr[7:0] == RISE_EN_OFF)
    |=> s_axi_rdata == {4'h0, $past(st_q.rise_en)})
    else $error("rising enable read mismatch");

  read_fall_a: assert property ( // R12
    @(posedge aclk) disable iff (!aresetn)
    (rd_go && s_axi_araddr[7:0] == FALL_EN_OFF)
    |=> s_axi_rdata == {4'h0, $past(st_q.fall_en)})
    else $error("falling enable read mismatch");

  rise_write_a: assert property ( // R12
    @(posedge aclk) disable iff (!aresetn)
    (wr_go && st_q.awaddr == RISE_EN_OFF && st_q.wstrb == 4'hF)
    |=> {4'h0, st_q.rise_en} == ($past(st_q.wdata) & 32'h0FFFFFFF))
    else $error("rising enable write lost");

  fall_write_a: assert property ( // R12
    @(posedge aclk) disable iff (!aresetn)
    (wr_go && st_q.awaddr == FALL_EN_OFF && st_q.wstrb == 4'hF)
    |=> {4'h0, st_q.fall_en} == ($past(st_q.wdata) & 32'h0FFFFFFF))
    else $error("falling enable write lost");

  unmapped_read_a: assert property ( // R12
    @(posedge aclk) disable iff (!aresetn)
    (rd_go && s_axi_araddr[7:0] != RISE_EN_OFF
      && s_axi_araddr[7:0] != FALL_EN_OFF
      && s_axi_araddr[7:0] != STATUS_OFF)
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered wrongly");

  unmapped_write_a: assert property ( // R12
    @(posedge aclk) disable iff (!aresetn)
    (wr_go && st_q.awaddr != RISE_EN_OFF && st_q.awaddr != FALL_EN_OFF
      && st_q.awaddr != STATUS_OFF)
    |=> s_axi_bresp == RESP_SLVERR && $stable(st_q.rise_en)
      && $stable(st_q.fall_en))
    else $error("unmapped write answered wrongly");

  write_answer_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_q.aw_held && st_q.w_held)
    |=> s_axi_bvalid)
    else $error("write not answered");

  read_answer_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready)
    |=> s_axi_rvalid)
    else $error("read not answered");

  //////////////////////////////////////////////////////////////////////////
  // covers
  cover_rise_c: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(st_q.status[27]));
  cover_clear_c: cover property (@(posedge aclk) disable iff (!aresetn)
    $fell(st_q.status[4]));
  cover_race_c: cover property (@(posedge aclk) disable iff (!aresetn)
    clr_mask[1] && edge_hit[1]);
  cover_read_c: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready);
  cover_lift_c: cover property (@(posedge aclk)
    $rose(aresetn) && st_q.sync2[0]);

endmodule

// ===== src/gpio_edge_pkg.sv
// What this block does
// (R1) rising enable set: low-to-high pin transition sets that pin's status bit
// (R2) falling enable set: high-to-low pin transition sets that pin's status bit
// (R3) both enables: either edge sets status; neither: status never set
// (R4) bits 27..0 per pin; bits 31..28 ignore writes, read zero
// (R5) reset loads enable registers with bits 1 and 0 one, rest zero
// (R6) matching edge sets status; read shows one where such edge occurred
// (R7) status bit stays set until software writes one to it
// (R8) writing zero to a status bit leaves it unchanged
// (R9) one shared request while any status bit 27..11 is set
// (R10) separate request per pin 10..0 while its status bit is set
// (R11) requests go out to interrupt controller for interrupt or wake
// (R12) rising enable at 0x10, falling enable at 0x14, status at 0x18
// (R13) pins synchronised by two flops, edge from level versus previous level
// (R14) new edge in same cycle as write-one clear keeps the bit set
package gpio_edge_pkg;
  localparam int          NUM_PINS      = 28;
  localparam int          SOLO_PINS     = 11;
  localparam logic [7:0]  RISE_EN_OFF   = 8'h10;
  localparam logic [7:0]  FALL_EN_OFF   = 8'h14;
  localparam logic [7:0]  STATUS_OFF    = 8'h18;
  localparam logic [27:0] ENABLE_RESET  = 28'h0000003;
  localparam logic [27:0] STATUS_RESET  = 28'h0000000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// ===== verif/pin_source.sv
module pin_source
  import gpio_edge_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic [27:0] level_req,
  output logic [27:0]      pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // external pins change just after a clock edge, always driven
  always @(posedge aclk)
    pin_in <= level_req;
endmodule

// ===== verif/gpio_edge_detect_tb_top.sv
module gpio_edge_detect_tb_top
  import gpio_edge_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define chk(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("unexpected at %0t: got %h expected %h", $time, g, e); \
    end \
  end
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, grp;
  logic [27:0] lvl, pins, rise_m, fall_m, stat_m, old;
  logic [31:0] awaddr, wdata, araddr, rdata, v;
  logic [10:0] pirq;
  logic [1:0]  bresp, rresp, r;
  int          failures, total_checks;
  //////////////////////////////////////////////////////////////////////////
  always #2 aclk = ~aclk;
  pin_source PS (.aclk(aclk), .level_req(lvl), .pin_in(pins));
  gpio_edge_detect DUT (.aclk(aclk), .aresetn(aresetn), .pin_in(pins),
    .pin_irq(pirq), .group_irq(grp), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  //////////////////////////////////////////////////////////////////////////
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic aw, w, b;
    awaddr <= {24'h000000, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b)
    begin
      @(negedge aclk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
    end
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar, rv;
    araddr <= {24'h000000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    rv = 1'b0;
    while (!rv)
    begin
      @(negedge aclk);
      ar = arvalid & arready;
      rv = rvalid;
      if (rv)
      begin
        `chk(rdata, e)
        `chk(rresp, er)
      end
      @(posedge aclk);
      if (ar)
        arvalid <= 1'b0;
    end
  endtask
  task irq_chk;
    @(negedge aclk);
    `chk(pirq, stat_m[10:0])
    `chk(grp, |stat_m[27:11])
    @(posedge aclk);
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {lvl, awaddr, wdata, araddr} = '0;
    failures = 0;
    total_checks = 0;
    void'($urandom(32'h28EF4D1A));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    stat_m = '0;
    rchk(RISE_EN_OFF, 32'h00000003, RESP_OKAY);
    rchk(FALL_EN_OFF, 32'h00000003, RESP_OKAY);
    rchk(STATUS_OFF, 32'h00000000, RESP_OKAY);
    wr(8'h1C, 32'hFFFFFFFF, r);
    `chk(r, RESP_SLVERR)
    rchk(8'h1C, 32'h00000000, RESP_SLVERR);
    repeat (60)
    begin
      v = $urandom;
      wr(RISE_EN_OFF, v, r);
      rise_m = v[27:0];
      v = $urandom;
      wr(FALL_EN_OFF, v, r);
      fall_m = v[27:0];
      rchk(RISE_EN_OFF, {4'h0, rise_m}, RESP_OKAY);
      rchk(FALL_EN_OFF, {4'h0, fall_m}, RESP_OKAY);
      old = lvl;
      v = $urandom;
      lvl <= v[27:0];
      stat_m |= (~old & v[27:0] & rise_m) | (old & ~v[27:0] & fall_m);
      repeat (8) @(posedge aclk);
      irq_chk();
      rchk(STATUS_OFF, {4'h0, stat_m}, RESP_OKAY);
      v = $urandom & $urandom;
      wr(STATUS_OFF, v, r);
      stat_m &= ~v[27:0];
      rchk(STATUS_OFF, {4'h0, stat_m}, RESP_OKAY);
      irq_chk();
    end
    // clear lands in the same cycle as an edge on every pin
    wr(RISE_EN_OFF, 32'hFFFFFFFF, r);
    wr(FALL_EN_OFF, 32'hFFFFFFFF, r);
    lvl <= ~lvl;
    repeat (2) @(posedge aclk);
    wr(STATUS_OFF, 32'hFFFFFFFF, r);
    stat_m = 28'hFFFFFFF;
    rchk(STATUS_OFF, {4'h0, stat_m}, RESP_OKAY);
    irq_chk();
    // second reset with pins 1 and 0 high: no false edge on release
    v = $urandom;
    lvl <= v[27:0] | 28'h0000003;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    stat_m = '0;
    repeat (8) @(posedge aclk);
    rchk(RISE_EN_OFF, 32'h00000003, RESP_OKAY);
    rchk(FALL_EN_OFF, 32'h00000003, RESP_OKAY);
    rchk(STATUS_OFF, {4'h0, stat_m}, RESP_OKAY);
    irq_chk();
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    report_and_stop();
  end
endmodule
